//--- rtl/afd_alu.sv
// Purpose: decode and compute one add or and instruction
// Assumes: purely combinational, flags at the mapped positions
// Notes: carry and half carry pass through unchanged for and
`timescale 1ns/1ps
`default_nettype none
`include "afd_map.svh"
module afd_alu (
  input wire logic [11:0] i_opcode,
  input wire logic [7:0] i_acc,
  input wire logic [7:0] i_file_val,
  input wire logic [2:0] i_status,
  input wire logic i_fuse,
  output afd_pkg::afd_alu_s o_res
);
  import afd_pkg::*;
  wire logic [6:0] op;
  wire logic add_file;
  wire logic add_acc;
  wire logic and_file;
  wire logic and_acc;
  wire logic is_add;
  wire logic cin;
  wire logic [8:0] sum9;
  wire logic [4:0] half5;
  // opcode decode on the upper seven bits
  assign op = i_opcode[11:5];
  assign add_file = (op == `AFD_OP_ADD_TO_FILE);
  assign add_acc = (op == `AFD_OP_ADD_TO_ACC);
  assign and_file = (op == `AFD_OP_AND_TO_FILE);
  assign and_acc = (op == `AFD_OP_AND_TO_ACC);
  assign is_add = add_file | add_acc;
  // fuse bit active when programmed low folds carry in
  assign cin = is_add & ~i_fuse & i_status[`AFD_C_BIT];
  // unsigned 9-bit sum, nibble sum for the half carry
  assign sum9 = {1'b0, i_file_val} + {1'b0, i_acc} + {8'h00, cin};
  assign half5 = {1'b0, i_file_val[3:0]} + {1'b0, i_acc[3:0]} + {4'h0, cin};
  // result and destination
  assign o_res.value = is_add ? sum9[7:0] : (i_file_val & i_acc);
  assign o_res.to_file = add_file | and_file;
  assign o_res.to_acc = add_acc | and_acc;
  assign o_res.legal = is_add | and_file | and_acc;
  // and keeps carry and half carry; zero always from stored byte
  assign o_res.flags[`AFD_C_BIT] =
    is_add ? sum9[8] : i_status[`AFD_C_BIT];
  assign o_res.flags[`AFD_DC_BIT] =
    is_add ? half5[4] : i_status[`AFD_DC_BIT];
  assign o_res.flags[`AFD_Z_BIT] = (o_res.value == 8'h00);
endmodule : afd_alu
`default_nettype wire

//--- rtl/afd_core.sv
// Purpose: add and and datapath with accumulator, file and status
// Assumes: axi4-lite slave, one write and one read under way at a time
// Notes: writing a legal opcode to the instruction word with both low strobe lanes executes it
//
// Register access over AXI4-Lite and the register offsets were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "afd_map.svh"
module afd_core #(
  parameter int ADDR_W = 8,
  parameter int NUM_FILES = 32
) (
  input wire logic i_core_clk,
  input wire logic i_reset_n,
  input wire logic i_awvalid,
  input wire logic [ADDR_W-1:0] i_awaddr,
  output logic o_awready,
  input wire logic i_wvalid,
  input wire logic [31:0] i_wdata,
  input wire logic [3:0] i_wstrb,
  output logic o_wready,
  output logic o_bvalid,
  output logic [1:0] o_bresp,
  input wire logic i_bready,
  input wire logic i_arvalid,
  input wire logic [ADDR_W-1:0] i_araddr,
  output logic o_arready,
  output logic o_rvalid,
  output logic [31:0] o_rdata,
  output logic [1:0] o_rresp,
  input wire logic i_rready
);
  import afd_pkg::*;

  //////////////////////////////////////////////////////////////////////////
  // address decode, shared by the write and read paths
  function automatic afd_sel_e afd_decode(input logic [ADDR_W-1:0] a);
    afd_sel_e s;
    s = AFD_SEL_NONE;
    if (a[`AFD_FILE_BASE_BIT] && a[1:0] == 2'h0) begin
      s = AFD_SEL_FILE;
    end else if (a == ADDR_W'(`AFD_OFF_INSTR)) begin
      s = AFD_SEL_INSTR;
    end else if (a == ADDR_W'(`AFD_OFF_ACC)) begin
      s = AFD_SEL_ACC;
    end else if (a == ADDR_W'(`AFD_OFF_STATUS)) begin
      s = AFD_SEL_STATUS;
    end else if (a == ADDR_W'(`AFD_OFF_CFG)) begin
      s = AFD_SEL_CFG;
    end
    return s;
  endfunction : afd_decode

  //////////////////////////////////////////////////////////////////////////
  // datapath state
  logic [7:0] acc_r;
  logic [2:0] status_r;
  logic fuse_r;
  logic [11:0] last_op_r;
  logic [7:0] file_q [NUM_FILES];

  // write channel state
  afd_wr_e wr_state_r;
  afd_wr_e wr_state_nxt;
  logic aw_got_r;
  logic w_got_r;
  logic [ADDR_W-1:0] awaddr_r;
  logic [31:0] wdata_r;
  logic [3:0] wstrb_r;

  // address and data may arrive in either order; take them as they come
  wire logic aw_take = i_awvalid & o_awready;
  wire logic w_take = i_wvalid & o_wready;
  wire logic aw_have = aw_got_r | aw_take;
  wire logic w_have = w_got_r | w_take;
  wire logic [ADDR_W-1:0] wr_addr = aw_got_r ? awaddr_r : i_awaddr;
  wire logic [31:0] wr_data = w_got_r ? wdata_r : i_wdata;
  wire logic [3:0] wr_strb = w_got_r ? wstrb_r : i_wstrb;
  wire logic wr_fire = (wr_state_r == AFD_WR_COLLECT) & aw_have & w_have;
  wire afd_sel_e wr_sel = afd_decode(wr_addr);
  wire logic [4:0] wr_fidx = wr_addr[6:2];
  wire logic wr_lo = wr_strb[0];
  wire logic aw_got_nxt = ~wr_fire & aw_have;
  wire logic w_got_nxt = ~wr_fire & w_have;

  // instruction path: operand address from low five opcode bits
  wire logic [11:0] opcode = wr_data[11:0];
  wire logic [4:0] op_fidx = opcode[4:0];
  wire logic [7:0] op_file_val = file_q[op_fidx];
  afd_alu_s alu;
  wire logic instr_wr = wr_fire & (wr_sel == AFD_SEL_INSTR);
  // a partial opcode write would execute garbage, so both low lanes needed
  wire logic exec = instr_wr & alu.legal & (wr_strb[1:0] == 2'h3);
  wire logic wr_err = (wr_sel == AFD_SEL_NONE) | (instr_wr & ~exec);

  afd_alu u_alu (
    .i_opcode(opcode),
    .i_acc(acc_r),
    .i_file_val(op_file_val),
    .i_status(status_r),
    .i_fuse(fuse_r),
    .o_res(alu)
  );

  // write state walk: collect both halves, then hold the response
  assign wr_state_nxt = wr_fire ? AFD_WR_RESP :
    ((wr_state_r == AFD_WR_RESP) & i_bready) ? AFD_WR_COLLECT : wr_state_r;

  //////////////////////////////////////////////////////////////////////////
  // write channel registers
  always_ff @(posedge i_core_clk) begin
    if (!i_reset_n) begin
      wr_state_r <= AFD_WR_COLLECT;
      aw_got_r <= 1'b0;
      w_got_r <= 1'b0;
      o_awready <= 1'b0;
      o_wready <= 1'b0;
      o_bvalid <= 1'b0;
      o_bresp <= `AFD_RESP_OKAY;
    end else begin
      case (wr_state_nxt)
        AFD_WR_COLLECT, AFD_WR_RESP: begin
          wr_state_r <= wr_state_nxt;
        end
        default: begin
          wr_state_r <= AFD_WR_COLLECT;
        end
      endcase
      aw_got_r <= aw_got_nxt;
      w_got_r <= w_got_nxt;
      o_awready <= (wr_state_nxt == AFD_WR_COLLECT) & ~aw_got_nxt;
      o_wready <= (wr_state_nxt == AFD_WR_COLLECT) & ~w_got_nxt;
      o_bvalid <= (wr_state_nxt == AFD_WR_RESP);
      if (wr_fire) begin
        o_bresp <= wr_err ? `AFD_RESP_SLVERR : `AFD_RESP_OKAY;
      end
    end
  end

  // payload holding, no reset needed on data
  always_ff @(posedge i_core_clk) begin
    if (aw_take) begin
      awaddr_r <= i_awaddr;
    end
    if (w_take) begin
      wdata_r <= i_wdata;
      wstrb_r <= i_wstrb;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // accumulator, status, fuse and last opcode, all settled in one edge
  always_ff @(posedge i_core_clk) begin
    if (!i_reset_n) begin
      acc_r <= `AFD_ACC_RST;
      status_r <= `AFD_STATUS_RST;
      fuse_r <= `AFD_FUSE_RST;
      last_op_r <= `AFD_INSTR_RST;
    end else begin
      if (exec & alu.to_acc) begin
        acc_r <= alu.value;
      end else if (wr_fire & (wr_sel == AFD_SEL_ACC) & wr_lo) begin
        acc_r <= wr_data[7:0];
      end
      if (exec) begin
        status_r <= alu.flags;
        last_op_r <= opcode;
      end else if (wr_fire & (wr_sel == AFD_SEL_STATUS) & wr_lo) begin
        status_r <= wr_data[2:0];
      end
      if (wr_fire & (wr_sel == AFD_SEL_CFG) & wr_lo) begin
        fuse_r <= wr_data[0];
      end
    end
  end

  // one small register per file word
  for (genvar gi = 0; gi < NUM_FILES; gi++) begin : g_file
    always_ff @(posedge i_core_clk) begin
      if (!i_reset_n) begin
        file_q[gi] <= `AFD_FILE_RST;
      end else if (exec & alu.to_file & (op_fidx == 5'(gi))) begin
        file_q[gi] <= alu.value;
      end else if (wr_fire & (wr_sel == AFD_SEL_FILE) & wr_lo &
                   (wr_fidx == 5'(gi))) begin
        file_q[gi] <= wr_data[7:0];
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // read channel: one cycle from address to data
  wire logic ar_take = i_arvalid & o_arready;
  wire afd_sel_e rd_sel = afd_decode(i_araddr);
  wire logic [7:0] rd_file = file_q[i_araddr[6:2]];
  wire logic [31:0] rd_mux =
    (rd_sel == AFD_SEL_INSTR) ? {20'h00000, last_op_r} :
    (rd_sel == AFD_SEL_ACC) ? {24'h000000, acc_r} :
    (rd_sel == AFD_SEL_STATUS) ? {29'h00000000, status_r} :
    (rd_sel == AFD_SEL_CFG) ? {31'h00000000, fuse_r} :
    (rd_sel == AFD_SEL_FILE) ? {24'h000000, rd_file} : 32'h00000000;

  always_ff @(posedge i_core_clk) begin
    if (!i_reset_n) begin
      o_arready <= 1'b0;
      o_rvalid <= 1'b0;
      o_rdata <= 32'h00000000;
      o_rresp <= `AFD_RESP_OKAY;
    end else if (ar_take) begin
      o_arready <= 1'b0;
      o_rvalid <= 1'b1;
      o_rdata <= rd_mux;
      o_rresp <= (rd_sel == AFD_SEL_NONE) ? `AFD_RESP_SLVERR : `AFD_RESP_OKAY;
    end else if (o_rvalid & i_rready) begin
      o_rvalid <= 1'b0;
      o_arready <= 1'b1;
    end else if (!o_rvalid) begin
      o_arready <= 1'b1;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // independent reference sums for the checks below
  wire logic ref_cin = ~fuse_r & status_r[0];
  wire logic [8:0] ref_sum9 =
    {1'b0, op_file_val} + {1'b0, acc_r} + {8'h00, ref_cin};
  wire logic [4:0] ref_half =
    {1'b0, op_file_val[3:0]} + {1'b0, acc_r[3:0]} + {4'h0, ref_cin};
  wire logic [7:0] ref_and = op_file_val & acc_r;
  wire logic ex_add = exec & (opcode[11:6] == 6'h07);
  wire logic ex_and = exec & (opcode[11:6] == 6'h05);

  a_add_file_dest: assert property (@(posedge i_core_clk)
    disable iff (!i_reset_n) (ex_add & opcode[5]) |=>
    (file_q[$past(op_fidx)] == $past(ref_sum9[7:0])) && $stable(acc_r))
    else $error("add to file result wrong");
  a_add_acc_dest: assert property (@(posedge i_core_clk)
    disable iff (!i_reset_n) (ex_add & ~opcode[5]) |=>
    (acc_r == $past(ref_sum9[7:0])) &&
    (file_q[$past(op_fidx)] == $past(op_file_val)))
    else $error("add to accumulator result wrong");
  a_add_carry: assert property (@(posedge i_core_clk)
    disable iff (!i_reset_n) ex_add |=> status_r[0] == $past(ref_sum9[8]))
    else $error("carry flag wrong after add");
  a_add_half: assert property (@(posedge i_core_clk)
    disable iff (!i_reset_n) ex_add |=> status_r[1] == $past(ref_half[4]))
    else $error("half carry flag wrong after add");
  a_add_zero: assert property (@(posedge i_core_clk)
    disable iff (!i_reset_n)
    ex_add |=> status_r[2] == ($past(ref_sum9[7:0]) == 8'h00))
    else $error("zero flag wrong after add");
  a_fuse_off_cin: assert property (@(posedge i_core_clk)
    disable iff (!i_reset_n) (ex_add & fuse_r) |=>
    status_r[0] == ($past({1'b0, op_file_val} + {1'b0, acc_r}) > 9'h0ff))
    else $error("carry folded in while fuse is off");
  a_and_file_dest: assert property (@(posedge i_core_clk)
    disable iff (!i_reset_n) (ex_and & opcode[5]) |=>
    (file_q[$past(op_fidx)] == $past(ref_and)) && $stable(acc_r))
    else $error("and to file result wrong");
  a_and_acc_dest: assert property (@(posedge i_core_clk)
    disable iff (!i_reset_n) (ex_and & ~opcode[5]) |=>
    (acc_r == $past(ref_and)) &&
    (file_q[$past(op_fidx)] == $past(op_file_val)))
    else $error("and to accumulator result wrong");
  a_and_flags_kept: assert property (@(posedge i_core_clk)
    disable iff (!i_reset_n) ex_and |=> $stable(status_r[1:0]) &&
    (status_r[2] == ($past(ref_and) == 8'h00)))
    else $error("and touched carry or zero wrong");
  a_write_resp: assert property (@(posedge i_core_clk)
    disable iff (!i_reset_n) wr_fire |=> o_bvalid && !o_awready)
    else $error("write response not raised after write");
endmodule : afd_core
`default_nettype wire

//--- rtl/afd_map.svh
// Purpose: register offsets, field positions, reset values and opcodes
// Assumes: byte addresses on a 32-bit AXI4-Lite register bus
// Notes: definitions only
`ifndef AFD_MAP_SVH
`define AFD_MAP_SVH
// register byte offsets
`define AFD_OFF_INSTR 8'h00
`define AFD_OFF_ACC 8'h04
`define AFD_OFF_STATUS 8'h08
`define AFD_OFF_CFG 8'h0c
`define AFD_FILE_BASE_BIT 7
// status flag positions
`define AFD_C_BIT 0
`define AFD_DC_BIT 1
`define AFD_Z_BIT 2
// reset values
`define AFD_ACC_RST 8'h00
`define AFD_STATUS_RST 3'h0
`define AFD_FILE_RST 8'h00
`define AFD_FUSE_RST 1'b1
`define AFD_INSTR_RST 12'h000
// opcode bits 11:5
`define AFD_OP_ADD_TO_FILE 7'h0f
`define AFD_OP_ADD_TO_ACC 7'h0e
`define AFD_OP_AND_TO_FILE 7'h0b
`define AFD_OP_AND_TO_ACC 7'h0a
// axi responses
`define AFD_RESP_OKAY 2'h0
`define AFD_RESP_SLVERR 2'h2
`endif

//--- rtl/afd_pkg.sv
// Purpose: shared types of the add and flag datapath
// Assumes: constants come from afd_map.svh
// Notes: none
package afd_pkg;
  // alu answer to one decoded instruction
  typedef struct packed {
    logic [7:0] value;
    logic [2:0] flags;
    logic to_file;
    logic to_acc;
    logic legal;
  } afd_alu_s;
  // register bus target of an address
  typedef enum logic [2:0] {
    AFD_SEL_NONE = 3'h0,
    AFD_SEL_INSTR = 3'h1,
    AFD_SEL_ACC = 3'h2,
    AFD_SEL_STATUS = 3'h3,
    AFD_SEL_CFG = 3'h4,
    AFD_SEL_FILE = 3'h5
  } afd_sel_e;
  // write channel progress, one-hot
  typedef enum logic [1:0] {
    AFD_WR_COLLECT = 2'b01,
    AFD_WR_RESP = 2'b10
  } afd_wr_e;
endpackage : afd_pkg

//--- tb/add_and_flag_datapath_tb.sv
// Purpose: self-checking bench of the add and and datapath
// Assumes: register map and opcodes as in afd_map.svh, one clock
// Notes: bench drives the register bus itself, ready lines held high
`timescale 1ns/1ps
`default_nettype none
`include "afd_map.svh"
module add_and_flag_datapath_tb;
  import afd_pkg::*;
  // one instruction case: preset state, opcode, expected state
  typedef struct packed {
    logic [11:0] op;
    logic [7:0] acc;
    logic [7:0] fv;
    logic [2:0] st;
    logic fuse;
    logic [7:0] eacc;
    logic [7:0] efile;
    logic [2:0] est;
  } afd_row_s;
  logic i_core_clk = 1'b0;
  logic i_reset_n = 1'b0;
  logic i_awvalid, i_wvalid, i_bready, i_arvalid, i_rready;
  logic [7:0] i_awaddr, i_araddr;
  logic [31:0] i_wdata;
  logic [3:0] i_wstrb;
  logic o_awready, o_wready, o_bvalid, o_arready, o_rvalid;
  logic [1:0] o_bresp, o_rresp, wresp, rs;
  logic [31:0] o_rdata, rd;
  int n_errors = 0;
  int total_checks = 0;
  int cycles = 0;
  afd_row_s rows [8];
  ////////////////////////////////////////////////////////////////////////
  afd_core u_afd_core (
    .i_core_clk(i_core_clk), .i_reset_n(i_reset_n),
    .i_awvalid(i_awvalid), .i_awaddr(i_awaddr), .o_awready(o_awready),
    .i_wvalid(i_wvalid), .i_wdata(i_wdata), .i_wstrb(i_wstrb),
    .o_wready(o_wready), .o_bvalid(o_bvalid), .o_bresp(o_bresp),
    .i_bready(i_bready), .i_arvalid(i_arvalid), .i_araddr(i_araddr),
    .o_arready(o_arready), .o_rvalid(o_rvalid), .o_rdata(o_rdata),
    .o_rresp(o_rresp), .i_rready(i_rready)
  );
  // 25 ns period
  always #12.5 i_core_clk = ~i_core_clk;
  // hang guard, the whole run needs a few hundred cycles
  always @(posedge i_core_clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      n_errors++;
      end_of_test();
    end
  end
  ////////////////////////////////////////////////////////////////////////
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : end_of_test
  // four-state compare so an unknown never matches
  task automatic chk(input logic [31:0] got, input logic [31:0] exp,
                     input string what);
    total_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("BAD t=%0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : chk
  // address and data offered together, each released when taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    input logic [3:0] s);
    logic aw_ok;
    logic w_ok;
    aw_ok = 1'b0;
    w_ok = 1'b0;
    i_awvalid <= 1'b1;
    i_awaddr <= a;
    i_wvalid <= 1'b1;
    i_wdata <= d;
    i_wstrb <= s;
    while (!(aw_ok && w_ok)) begin
      @(posedge i_core_clk);
      if (i_awvalid && o_awready === 1'b1) begin
        aw_ok = 1'b1;
        i_awvalid <= 1'b0;
      end
      if (i_wvalid && o_wready === 1'b1) begin
        w_ok = 1'b1;
        i_wvalid <= 1'b0;
      end
    end
    do @(posedge i_core_clk); while (o_bvalid !== 1'b1);
    wresp = o_bresp;
  endtask : wr
  task automatic rdt(input logic [7:0] a);
    i_arvalid <= 1'b1;
    i_araddr <= a;
    do @(posedge i_core_clk); while (o_arready !== 1'b1);
    i_arvalid <= 1'b0;
    do @(posedge i_core_clk); while (o_rvalid !== 1'b1);
    rd = o_rdata;
    rs = o_rresp;
  endtask : rdt
  function automatic logic [7:0] fa(input logic [4:0] n);
    return {1'b1, n, 2'b00};
  endfunction : fa
  ////////////////////////////////////////////////////////////////////////
  initial begin
    i_awvalid = 1'b0;
    i_wvalid = 1'b0;
    i_arvalid = 1'b0;
    i_awaddr = 8'h00;
    i_araddr = 8'h00;
    i_wdata = 32'h0;
    i_wstrb = 4'h0;
    i_bready = 1'b1;
    i_rready = 1'b1;
    // op, acc, file, status, fuse, then expected acc, file, status
    rows = '{'{12'h1f2, 8'h02, 8'h7f, 3'h0, 1'b1, 8'h02, 8'h81, 3'h2},
             '{12'h1d2, 8'h82, 8'h81, 3'h0, 1'b1, 8'h03, 8'h81, 3'h1},
             '{12'h1df, 8'h80, 8'h80, 3'h0, 1'b1, 8'h00, 8'h80, 3'h5},
             '{12'h1e0, 8'h0f, 8'h00, 3'h1, 1'b0, 8'h0f, 8'h10, 3'h2},
             '{12'h1c1, 8'hff, 8'h00, 3'h1, 1'b0, 8'h00, 8'h00, 3'h7},
             '{12'h1c1, 8'h01, 8'h01, 3'h1, 1'b1, 8'h02, 8'h01, 3'h0},
             '{12'h170, 8'h13, 8'h0f, 3'h7, 1'b1, 8'h13, 8'h03, 3'h3},
             '{12'h14b, 8'h50, 8'h0f, 3'h1, 1'b1, 8'h00, 8'h0f, 3'h5}};
    repeat (2) @(posedge i_core_clk);
    i_reset_n <= 1'b1;
    repeat (2) @(posedge i_core_clk);
    // table of instruction cases
    foreach (rows[i]) begin
      wr(`AFD_OFF_CFG, {31'h0, rows[i].fuse}, 4'hf);
      wr(`AFD_OFF_ACC, {24'h0, rows[i].acc}, 4'hf);
      wr(`AFD_OFF_STATUS, {29'h0, rows[i].st}, 4'hf);
      wr(fa(rows[i].op[4:0]), {24'h0, rows[i].fv}, 4'hf);
      wr(`AFD_OFF_INSTR, {20'h0, rows[i].op}, 4'hf);
      chk(wresp, `AFD_RESP_OKAY, "exec resp");
      rdt(`AFD_OFF_ACC);
      chk(rd, rows[i].eacc, "acc");
      rdt(fa(rows[i].op[4:0]));
      chk(rd, rows[i].efile, "file");
      rdt(`AFD_OFF_STATUS);
      chk(rd, rows[i].est, "flags");
    end
    rdt(`AFD_OFF_INSTR);
    chk(rd, 32'h14b, "last opcode");
    $display("table cases done");
    // second instruction must see the first one's file result
    wr(`AFD_OFF_ACC, 32'h01, 4'hf);
    wr(`AFD_OFF_STATUS, 32'h0, 4'hf);
    wr(fa(5'h02), 32'h01, 4'hf);
    wr(`AFD_OFF_INSTR, 32'h1e2, 4'hf);
    wr(`AFD_OFF_INSTR, 32'h1c2, 4'hf);
    rdt(`AFD_OFF_ACC);
    chk(rd, 32'h03, "chained acc");
    rdt(`AFD_OFF_STATUS);
    chk(rd, 32'h0, "chained flags in bits 2:0");
    $display("back to back done");
    // refused writes and an unmapped place leave state alone
    wr(`AFD_OFF_INSTR, 32'h1a2, 4'hf);
    chk(wresp, `AFD_RESP_SLVERR, "bad opcode");
    wr(`AFD_OFF_INSTR, 32'h1c2, 4'h1);
    chk(wresp, `AFD_RESP_SLVERR, "partial strobe");
    wr(8'h14, 32'hff, 4'hf);
    chk(wresp, `AFD_RESP_SLVERR, "unmapped write");
    rdt(8'h10);
    chk({rs, rd}, {`AFD_RESP_SLVERR, 32'h0}, "unmapped read");
    rdt(`AFD_OFF_ACC);
    chk(rd, 32'h03, "acc after refusals");
    $display("refusals done");
    // mid-run reset restores every reset value
    i_reset_n <= 1'b0;
    repeat (2) @(posedge i_core_clk);
    i_reset_n <= 1'b1;
    repeat (2) @(posedge i_core_clk);
    rdt(`AFD_OFF_ACC);
    chk(rd, `AFD_ACC_RST, "acc reset");
    rdt(`AFD_OFF_STATUS);
    chk(rd, `AFD_STATUS_RST, "status reset");
    rdt(`AFD_OFF_CFG);
    chk(rd, `AFD_FUSE_RST, "fuse reset");
    rdt(fa(5'h02));
    chk(rd, `AFD_FILE_RST, "file reset");
    rdt(`AFD_OFF_INSTR);
    chk(rd, `AFD_INSTR_RST, "opcode reset");
    $display("reset done");
    end_of_test();
  end
endmodule : add_and_flag_datapath_tb
`default_nettype wire
